// [dhi_top.sv]
`timescale 1ns/1ps
module dhi_top #(
    parameter int unsigned RESET_CYCLES = dhi_pkg::RESET_DELAY_CYC
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    // jumpers
    input  wire logic [1:0]  mode_sel_in,
    input  wire logic        width4_in,
    // parallel port
    input  wire logic        reg_select_in,
    input  wire logic        rw_in,
    input  wire logic        enable_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic [7:0]  data_bus_in,
    output logic      [7:0]  data_bus_out,
    output logic             data_bus_oe_out,
    // serial port
    input  wire logic        frame_strobe_n_in,
    input  wire logic        sck_in,
    input  wire logic        sio_in,
    output logic             sio_out,
    output logic             sio_oe_out,
    // apb
    input  wire logic [11:0] paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out
);
    logic [18:0] s;
    logic [1:0]  mode_s;
    logic        w4_s, sel_s, rw_s, en_s, rd_s, wr_s, frm_s, sck_s, si_s;
    logic [7:0]  db_s;

    dhi_sync #(.W(dhi_pkg::SYNC_W), .RST(dhi_pkg::SYNC_RST)) u_sync (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .d_in      ({mode_sel_in, width4_in, reg_select_in, rw_in,
                     enable_in, rd_n_in, wr_n_in, frame_strobe_n_in,
                     data_bus_in, sck_in, sio_in}),
        .q_out     (s)
    );
    assign {mode_s, w4_s, sel_s, rw_s, en_s, rd_s, wr_s, frm_s,
            db_s, sck_s, si_s} = s;

    // power-up hold and jumper capture
    logic [22:0] rdy_cnt_r, rdy_cnt_nxt;
    logic        ready_r, ready_nxt, w4_r, w4_nxt;
    logic [1:0]  mode_r, mode_nxt;

    always_comb begin
        rdy_cnt_nxt = rdy_cnt_r;
        ready_nxt   = ready_r;
        mode_nxt    = mode_r;
        w4_nxt      = w4_r;
        if (!ready_r) begin
            rdy_cnt_nxt = rdy_cnt_r + 23'h000001;
            if (rdy_cnt_r == 23'(RESET_CYCLES - 1)) begin
                ready_nxt = 1'b1;
                mode_nxt  = mode_s;
                w4_nxt    = w4_s;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdy_cnt_r <= 23'h000000;
            ready_r   <= 1'b0;
            mode_r    <= dhi_pkg::MODE_RST;
            w4_r      <= 1'b0;
        end else begin
            rdy_cnt_r <= rdy_cnt_nxt;
            ready_r   <= ready_nxt;
            mode_r    <= mode_nxt;
            w4_r      <= w4_nxt;
        end
    end

    // serial engine
    dhi_xfer_if xfer ();
    logic [14:0] rddata_r, rddata_nxt;

    dhi_serial u_serial (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .active_in (ready_r && mode_r == dhi_pkg::MODE_SERIAL),
        .frm_n_in  (frm_s),
        .sck_in    (sck_s),
        .si_in     (si_s),
        .xfer      (xfer),
        .so_out    (sio_out),
        .so_oe_out (sio_oe_out)
    );
    assign xfer.rd_data = xfer.rd_sel ? rddata_r[7:0]
                                     : {1'b0, rddata_r[14:8]};

    // parallel port
    logic       en_p_r, rd_p_r, wr_p_r, phase_r, phase_nxt;
    logic [3:0] hi_nib_r, hi_nib_nxt;
    logic       evt_r, evt_nxt, evt_sel_r, evt_sel_nxt;
    logic [7:0] evt_data_r, evt_data_nxt, dout_nxt, rd_byte;
    logic       oe_nxt, out_sel_r, out_sel_nxt;
    logic       p_e, p_s, wr_edge, rd_edge, rd_end;

    assign p_e     = ready_r && mode_r == dhi_pkg::MODE_ESTROBE;
    assign p_s     = ready_r && mode_r == dhi_pkg::MODE_SSTROBE;
    assign wr_edge = (p_e && en_p_r && !en_s && !rw_s)
                   || (p_s && !wr_p_r && wr_s);
    assign rd_edge = (p_e && !en_p_r && en_s && rw_s)
                   || (p_s && rd_p_r && !rd_s);
    assign rd_end  = (p_e && en_p_r && !en_s) || (p_s && !rd_p_r && rd_s);
    assign rd_byte = sel_s ? rddata_r[7:0] : {1'b0, rddata_r[14:8]};

    always_comb begin
        phase_nxt    = phase_r;
        hi_nib_nxt   = hi_nib_r;
        evt_nxt      = 1'b0;
        evt_sel_nxt  = evt_sel_r;
        evt_data_nxt = evt_data_r;
        dout_nxt     = data_bus_out;
        oe_nxt       = data_bus_oe_out;
        out_sel_nxt  = out_sel_r;
        if (wr_edge) begin
            evt_sel_nxt = sel_s;
            if (w4_r) begin
                phase_nxt = !phase_r;
                if (!phase_r) begin
                    hi_nib_nxt = db_s[7:4];
                end else begin
                    evt_nxt      = 1'b1;
                    evt_data_nxt = {hi_nib_r, db_s[7:4]};
                end
            end else begin
                evt_nxt      = 1'b1;
                evt_data_nxt = db_s;
            end
        end else if (rd_edge) begin
            oe_nxt     = 1'b1;
            out_sel_nxt = sel_s;
            if (w4_r) begin
                phase_nxt = !phase_r;
                dout_nxt  = phase_r ? {rd_byte[3:0], 4'h0}
                                    : {rd_byte[7:4], 4'h0};
            end else begin
                dout_nxt = rd_byte;
            end
        end else if (rd_end) begin
            oe_nxt = 1'b0;
        end
        if (xfer.wr_valid) begin
            evt_nxt      = 1'b1;
            evt_sel_nxt  = xfer.wr_sel;
            evt_data_nxt = xfer.wr_data;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_p_r          <= 1'b0;
            rd_p_r          <= 1'b1;
            wr_p_r          <= 1'b1;
            phase_r         <= 1'b0;
            hi_nib_r        <= 4'h0;
            evt_r           <= 1'b0;
            evt_sel_r       <= 1'b0;
            evt_data_r      <= dhi_pkg::BYTE_RST;
            data_bus_out    <= dhi_pkg::BYTE_RST;
            data_bus_oe_out <= 1'b0;
            out_sel_r       <= 1'b0;
        end else begin
            en_p_r          <= en_s;
            rd_p_r          <= rd_s;
            wr_p_r          <= wr_s;
            phase_r         <= phase_nxt;
            hi_nib_r        <= hi_nib_nxt;
            evt_r           <= evt_nxt;
            evt_sel_r       <= evt_sel_nxt;
            evt_data_r      <= evt_data_nxt;
            data_bus_out    <= dout_nxt;
            data_bus_oe_out <= oe_nxt;
            out_sel_r       <= out_sel_nxt;
        end
    end

    // apb slave, one wait state per access
    logic        acc, hit, wr_do;
    logic        rxv_r, rxv_nxt, rxrs_r, rxrs_nxt;
    logic [7:0]  rxb_r, rxb_nxt;
    logic [31:0] prdata_nxt, rmux;
    logic        pready_nxt, pslverr_nxt;

    assign acc   = psel_in && penable_in;
    assign hit   = paddr_in == dhi_pkg::ADDR_RDDATA
                 || paddr_in == dhi_pkg::ADDR_RX
                 || paddr_in == dhi_pkg::ADDR_RXCLR
                 || paddr_in == dhi_pkg::ADDR_STATUS;
    assign wr_do = acc && pready_out && pwrite_in && hit;

    always_comb begin
        case (paddr_in)
            dhi_pkg::ADDR_RDDATA: rmux = {17'h00000, rddata_r};
            dhi_pkg::ADDR_RX:     rmux = {22'h000000, rxv_r, rxrs_r, rxb_r};
            dhi_pkg::ADDR_STATUS: rmux = {27'h0000000, ready_r, w4_r,
                                          mode_r, 1'b0};
            default:              rmux = 32'h00000000;
        endcase
        pready_nxt  = acc && !pready_out;
        prdata_nxt  = prdata_out;
        pslverr_nxt = pslverr_out;
        if (acc && !pready_out) begin
            prdata_nxt  = rmux;
            pslverr_nxt = !hit;
        end
        rddata_nxt = rddata_r;
        if (wr_do && paddr_in == dhi_pkg::ADDR_RDDATA) begin
            rddata_nxt = pwdata_in[14:0];
        end
        rxv_nxt  = rxv_r;
        rxrs_nxt = rxrs_r;
        rxb_nxt  = rxb_r;
        if (wr_do && paddr_in == dhi_pkg::ADDR_RXCLR && pwdata_in[0]) begin
            rxv_nxt = 1'b0;
        end
        // a byte landing in the clear cycle must not vanish
        if (evt_r) begin
            rxv_nxt  = 1'b1;
            rxrs_nxt = evt_sel_r;
            rxb_nxt  = evt_data_r;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_out  <= 32'h00000000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            rddata_r    <= dhi_pkg::RDDATA_RST;
            rxv_r       <= 1'b0;
            rxrs_r      <= 1'b0;
            rxb_r       <= dhi_pkg::BYTE_RST;
        end else begin
            prdata_out  <= prdata_nxt;
            pready_out  <= pready_nxt;
            pslverr_out <= pslverr_nxt;
            rddata_r    <= rddata_nxt;
            rxv_r       <= rxv_nxt;
            rxrs_r      <= rxrs_nxt;
            rxb_r       <= rxb_nxt;
        end
    end

    AST_E_WRITE: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (p_e && !w4_r && en_p_r && !en_s && !rw_s)
        |=> evt_r && evt_data_r == $past(db_s))
        else $error("enable write not captured");
    AST_S_WRITE: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (p_s && !w4_r && !wr_p_r && wr_s)
        |=> evt_r && evt_sel_r == $past(sel_s))
        else $error("write strobe not captured");
    AST_NIB_JOIN: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (wr_edge && w4_r && phase_r)
        |=> evt_r && evt_data_r == {$past(hi_nib_r), $past(db_s[7:4])}
            && !phase_r)
        else $error("nibbles not joined");
    AST_E_READ: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (p_e && !en_p_r && en_s && rw_s) |=> data_bus_oe_out [*1] ##1 1'b1)
        else $error("enable read not driven");
    AST_RD_DRIVE: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (p_s && rd_p_r && !rd_s) |=> data_bus_oe_out)
        else $error("read strobe not driven");
    AST_BUSY_ZERO: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (data_bus_oe_out && !out_sel_r && !(w4_r && !phase_r))
        |-> !data_bus_out[7])
        else $error("busy bit not zero");
    AST_APB_WAIT: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (acc && !pready_out) |=> pready_out ##1 !pready_out)
        else $error("apb answer not in one wait");
    AST_HOLD_OFF: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        !ready_r |-> !evt_r && !data_bus_oe_out)
        else $error("transfer during power-up hold");
    AST_SER_TURN: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        xfer.rd_start |-> !sio_oe_out)
        else $error("serial line turned before payload");
endmodule

// [dhi_pkg.sv]
package dhi_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned RESET_DELAY_MS  = 100;
    localparam int unsigned RESET_DELAY_CYC = (CLK_HZ / 1000) * RESET_DELAY_MS;
    localparam int unsigned RDY_CNT_W       = 23;

    localparam logic [11:0] ADDR_RDDATA = 12'h000;
    localparam logic [11:0] ADDR_RX     = 12'h004;
    localparam logic [11:0] ADDR_RXCLR  = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    localparam logic [14:0] RDDATA_RST  = 15'h0000;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic [3:0]  CNT_RST     = 4'h0;
    localparam logic [3:0]  BYTE_BITS   = 4'h8;
    localparam logic [3:0]  LAST_BIT    = 4'h7;
    localparam logic [4:0]  START_ONES  = 5'h1F;
    localparam logic [1:0]  MODE_RST    = 2'h0;

    // jumper encodings
    localparam logic [1:0]  MODE_ESTROBE = 2'h0;
    localparam logic [1:0]  MODE_SSTROBE = 2'h1;
    localparam logic [1:0]  MODE_SERIAL  = 2'h2;

    // sync vector layout
    localparam int unsigned SYNC_W   = 19;
    // idle levels: read, write and frame strobes high, serial clock high
    localparam logic [18:0] SYNC_RST = 19'h01C02;

    typedef enum logic [4:0] {
        SER_IDLE  = 5'b00001,
        SER_START = 5'b00010,
        SER_WPAY  = 5'b00100,
        SER_RPAY  = 5'b01000,
        SER_DROP  = 5'b10000
    } dhi_ser_e;
endpackage

// [dhi_xfer_if.sv]
`timescale 1ns/1ps
interface dhi_xfer_if;
    logic       wr_valid;
    logic       wr_sel;
    logic [7:0] wr_data;
    logic       rd_start;
    logic       rd_sel;
    logic [7:0] rd_data;
    modport eng (output wr_valid, wr_sel, wr_data, rd_start, rd_sel,
                 input  rd_data);
    modport core (input  wr_valid, wr_sel, wr_data, rd_start, rd_sel,
                  output rd_data);
endinterface

// [dhi_sync.sv]
`timescale 1ns/1ps
module dhi_sync #(
    parameter int unsigned          W   = 1,
    parameter logic [W-1:0]         RST = '0
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         arst_n_in,
    // async in, synced out
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    meta_r[i] <= RST[i];
                    q_out[i]  <= RST[i];
                end else begin
                    meta_r[i] <= d_in[i];
                    q_out[i]  <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// [dhi_serial.sv]
`timescale 1ns/1ps
module dhi_serial (
    // clock and reset
    input  wire logic     clk_in,
    input  wire logic     arst_n_in,
    // active flag and synced pins
    input  wire logic     active_in,
    input  wire logic     frm_n_in,
    input  wire logic     sck_in,
    input  wire logic     si_in,
    // core side
    dhi_xfer_if.eng       xfer,
    // serial output pin
    output logic          so_out,
    output logic          so_oe_out
);
    dhi_pkg::dhi_ser_e st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic       rw_r, rw_nxt, sel_r, sel_nxt;
    logic       so_nxt, oe_nxt, wv_r, wv_nxt, rds_r, rds_nxt;
    logic       frm_prev_r, sck_prev_r;
    logic       frm_fall, frm_rise, sck_rise, sck_fall;
    logic [7:0] sbyte;

    assign frm_fall = frm_prev_r & ~frm_n_in;
    assign frm_rise = ~frm_prev_r & frm_n_in;
    assign sck_rise = ~sck_prev_r & sck_in;
    assign sck_fall = sck_prev_r & ~sck_in;
    assign sbyte    = {sh_r[6:0], si_in};

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        sh_nxt  = sh_r;
        rw_nxt  = rw_r;
        sel_nxt = sel_r;
        so_nxt  = so_out;
        oe_nxt  = so_oe_out;
        wv_nxt  = 1'b0;
        rds_nxt = 1'b0;
        case (st_r)
            dhi_pkg::SER_IDLE: begin
                oe_nxt = 1'b0;
                if (frm_fall && active_in) begin
                    st_nxt  = dhi_pkg::SER_START;
                    cnt_nxt = dhi_pkg::CNT_RST;
                end
            end
            dhi_pkg::SER_START: begin
                if (frm_rise) begin
                    st_nxt = dhi_pkg::SER_IDLE;
                end else if (sck_rise) begin
                    sh_nxt  = sbyte;
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == dhi_pkg::LAST_BIT) begin
                        cnt_nxt = dhi_pkg::CNT_RST;
                        if (sbyte[7:3] == dhi_pkg::START_ONES
                                && !sbyte[0]) begin
                            rw_nxt  = sbyte[2];
                            sel_nxt = sbyte[1];
                            rds_nxt = sbyte[2];
                            st_nxt  = sbyte[2] ? dhi_pkg::SER_RPAY
                                               : dhi_pkg::SER_WPAY;
                        end else begin
                            st_nxt = dhi_pkg::SER_DROP;
                        end
                    end
                end
            end
            dhi_pkg::SER_WPAY: begin
                if (frm_rise) begin
                    // only a completed frame closed by the strobe counts
                    wv_nxt = (cnt_r == dhi_pkg::BYTE_BITS);
                    st_nxt = dhi_pkg::SER_IDLE;
                end else if (sck_rise && cnt_r != dhi_pkg::BYTE_BITS) begin
                    sh_nxt  = sbyte;
                    cnt_nxt = cnt_r + 4'h1;
                end
            end
            dhi_pkg::SER_RPAY: begin
                if (frm_rise) begin
                    st_nxt = dhi_pkg::SER_IDLE;
                    oe_nxt = 1'b0;
                end else if (sck_fall && cnt_r != dhi_pkg::BYTE_BITS) begin
                    // host owns the 1 us gap; first fall turns the line
                    oe_nxt  = 1'b1;
                    cnt_nxt = cnt_r + 4'h1;
                    if (cnt_r == dhi_pkg::CNT_RST) begin
                        so_nxt = xfer.rd_data[7];
                        sh_nxt = {xfer.rd_data[6:0], 1'b0};
                    end else begin
                        so_nxt = sh_r[7];
                        sh_nxt = {sh_r[6:0], 1'b0};
                    end
                end
            end
            dhi_pkg::SER_DROP: begin
                if (frm_rise) begin
                    st_nxt = dhi_pkg::SER_IDLE;
                end
            end
            default: begin
                st_nxt = dhi_pkg::SER_IDLE;
                oe_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r       <= dhi_pkg::SER_IDLE;
            cnt_r      <= dhi_pkg::CNT_RST;
            sh_r       <= dhi_pkg::BYTE_RST;
            rw_r       <= 1'b0;
            sel_r      <= 1'b0;
            so_out     <= 1'b0;
            so_oe_out  <= 1'b0;
            wv_r       <= 1'b0;
            rds_r      <= 1'b0;
            frm_prev_r <= 1'b1;
            // idle-high clock: no false edge right after reset
            sck_prev_r <= 1'b1;
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            rw_r       <= rw_nxt;
            sel_r      <= sel_nxt;
            so_out     <= so_nxt;
            so_oe_out  <= oe_nxt;
            wv_r       <= wv_nxt;
            rds_r      <= rds_nxt;
            frm_prev_r <= frm_n_in;
            sck_prev_r <= sck_in;
        end
    end

    assign xfer.wr_valid = wv_r;
    assign xfer.wr_sel   = sel_r;
    assign xfer.wr_data  = sh_r;
    assign xfer.rd_start = rds_r;
    assign xfer.rd_sel   = sel_r;

    AST_SER_LAST_ZERO: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (st_r == dhi_pkg::SER_START && sck_rise && !frm_rise
            && cnt_r == dhi_pkg::LAST_BIT && si_in)
        |=> st_r == dhi_pkg::SER_DROP)
        else $error("bad start byte not dropped");
    AST_SER_WR_FULL: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        wv_r |-> $past(cnt_r) == dhi_pkg::BYTE_BITS && $past(frm_n_in)
            && !$past(frm_prev_r))
        else $error("serial write without full frame");
    AST_SER_END: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        (frm_rise && st_r != dhi_pkg::SER_IDLE)
        |=> st_r == dhi_pkg::SER_IDLE ##1 !so_oe_out)
        else $error("frame not closed by strobe");
    AST_SER_OE_READ: assert property (@(posedge clk_in)
        disable iff (!arst_n_in)
        so_oe_out |-> rw_r && $past(st_r) == dhi_pkg::SER_RPAY)
        else $error("serial drive outside read");
endmodule

// [dhi_host_model.sv]
`timescale 1ns/1ps
module dhi_host_model (
    // clock
    input  wire logic clk_in,
    // serial wire
    input  wire logic so_in,
    output logic      sck_out,
    output logic      frm_n_out,
    output logic      si_out,
    output logic      si_oe_out
);
    // clock idles high outside frames and across the byte gap
    initial begin
        sck_out   = 1'b1;
        frm_n_out = 1'b1;
        si_out    = 1'b0;
        si_oe_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // n below 8 sends a short payload, which must be discarded
    task automatic frame(input logic rd, input logic sel,
                         input logic [7:0] pay, input int n,
                         output logic [7:0] q);
        logic [7:0] sb;
        q  = 8'h00;
        sb = {5'h1F, rd, sel, 1'b0};
        tick(1);
        frm_n_out <= 1'b0;
        tick(6);
        for (int i = 7; i >= 0; i--) begin
            si_out  <= sb[i];
            sck_out <= 1'b0;
            tick(4);
            sck_out <= 1'b1;
            tick(4);
        end
        // free the line before the device may turn it around
        if (rd) begin
            si_oe_out <= 1'b0;
        end
        tick(60);
        for (int i = 7; i >= 8 - n; i--) begin
            si_out  <= pay[i];
            sck_out <= 1'b0;
            tick(4);
            sck_out <= 1'b1;
            tick(4);
            // read bit late in the high phase, well after its fall
            q[i] = so_in;
        end
        tick(8);
        frm_n_out <= 1'b1;
        tick(30);
        si_oe_out <= 1'b1;
    endtask
endmodule

// [dhi_top_tb.sv]
`timescale 1ns/1ps
module dhi_top_tb;
    localparam int RST_CYC = 16;
    logic        clk_in = 1'b0, arst_n_in = 1'b0;
    logic [1:0]  mode_sel = 2'h0;
    logic        width4 = 1'b0, reg_select = 1'b0, rw = 1'b0;
    logic        enable = 1'b0, rd_n = 1'b1, wr_n = 1'b1, h_drv = 1'b1;
    logic [7:0]  h_db = 8'h00, db_out, q, q_bus;
    logic        db_oe, sio_out, sio_oe, sck, frm_n, h_si, h_oe, q_oe;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_r;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr;
    wire  [7:0]  db_w = db_oe ? db_out : (h_drv ? h_db : ~db_out);
    wire         sio_w = sio_oe ? sio_out : (h_oe ? h_si : ~sio_out);
    int          fail_count = 0, comparisons = 0;

    always #10 clk_in = ~clk_in;

    dhi_top #(.RESET_CYCLES(RST_CYC)) dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .mode_sel_in(mode_sel),
        .width4_in(width4), .reg_select_in(reg_select), .rw_in(rw),
        .enable_in(enable), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .data_bus_in(db_w), .data_bus_out(db_out), .data_bus_oe_out(db_oe),
        .frame_strobe_n_in(frm_n), .sck_in(sck), .sio_in(sio_w),
        .sio_out(sio_out), .sio_oe_out(sio_oe), .paddr_in(paddr),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr));

    dhi_host_model host_u (.clk_in(clk_in), .so_in(sio_w), .sck_out(sck),
        .frm_n_out(frm_n), .si_out(h_si), .si_oe_out(h_oe));

    task automatic test_done();
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        // wait on pready alone; only the watchdog ends a hang
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        r = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rx(input logic [31:0] exp);
        apb(1'b0, dhi_pkg::ADDR_RX, 32'h0, rd);
        chk(rd, exp);
    endtask

    // mode latches only once per reset, so each mode needs its own reset
    task automatic rst(input logic [1:0] m, input logic w4);
        @(posedge clk_in);
        mode_sel <= m; width4 <= w4; arst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (RST_CYC + 12) @(posedge clk_in);
        apb(1'b1, dhi_pkg::ADDR_RDDATA, 32'h0000_2A5A, rd);
    endtask

    task automatic par(input logic r, input logic sel, input logic [7:0] d);
        @(posedge clk_in);
        reg_select <= sel;
        rw <= r;
        h_db <= d;
        h_drv <= !r;
        repeat (2) @(posedge clk_in);
        if (mode_sel == dhi_pkg::MODE_SSTROBE) begin
            if (r) rd_n <= 1'b0;
            else wr_n <= 1'b0;
        end else begin
            enable <= 1'b1;
        end
        repeat (8) @(posedge clk_in);
        q_bus = db_out;
        q_oe = db_oe;
        rd_n <= 1'b1; wr_n <= 1'b1; enable <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask

    initial begin
        repeat (10000) @(posedge clk_in);
        fail_count++;
        test_done();
    end

    initial begin
        rst(dhi_pkg::MODE_ESTROBE, 1'b0);
        apb(1'b0, dhi_pkg::ADDR_STATUS, 32'h0, rd);
        chk(rd, 32'h0000_0010);
        apb(1'b0, 12'h010, 32'h0, rd);
        chk({rd[30:0], err_r}, 32'h0000_0001);
        par(1'b0, 1'b1, 8'hA5);
        rx(32'h0000_03A5);
        par(1'b0, 1'b0, 8'h3C);
        rx(32'h0000_023C);
        apb(1'b1, dhi_pkg::ADDR_RXCLR, 32'h0000_0001, rd);
        rx(32'h0000_003C);
        par(1'b1, 1'b1, 8'h00);
        chk({q_oe, q_bus}, 32'h0000_015A);
        par(1'b1, 1'b0, 8'h00);
        chk({q_oe, q_bus}, 32'h0000_012A);
        rst(dhi_pkg::MODE_SSTROBE, 1'b1);
        apb(1'b0, dhi_pkg::ADDR_STATUS, 32'h0, rd);
        chk(rd, 32'h0000_001A);
        par(1'b0, 1'b1, 8'hC7);
        par(1'b0, 1'b1, 8'h3F);
        rx(32'h0000_03C3);
        par(1'b1, 1'b1, 8'h00);
        chk({q_oe, q_bus}, 32'h0000_0150);
        par(1'b1, 1'b1, 8'h00);
        chk({q_oe, q_bus}, 32'h0000_01A0);
        rst(dhi_pkg::MODE_SERIAL, 1'b0);
        host_u.frame(1'b0, 1'b0, 8'h96, 8, q);
        rx(32'h0000_0296);
        host_u.frame(1'b1, 1'b1, 8'h00, 8, q);
        chk({24'h0, q}, 32'h0000_005A);
        host_u.frame(1'b1, 1'b0, 8'h00, 8, q);
        chk({24'h0, q}, 32'h0000_002A);
        apb(1'b1, dhi_pkg::ADDR_RXCLR, 32'h0000_0001, rd);
        host_u.frame(1'b0, 1'b1, 8'hE1, 7, q);
        rx(32'h0000_0096);
        rst(dhi_pkg::MODE_SSTROBE, 1'b0);
        par(1'b0, 1'b0, 8'h81);
        rx(32'h0000_0281);
        test_done();
    end
endmodule
